//--- pta_checker_asserts.sv
// Purpose: Port-level checks for the protection trip aggregator.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Sees the top module ports only; settings are invisible here.
`include "pta_consts.svh"
`timescale 1ns/1ps
module pta_checker #(
    parameter int N_ELEM = `PTA_ELEMENTS
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Watched inputs
    input wire logic i_setting_change_busy,
    input wire logic i_measured_values_ok,
    input wire logic [N_ELEM-1:0] i_elem_alarm,
    input wire logic [N_ELEM-1:0] i_elem_trip,
    input wire logic [N_ELEM*`PTA_PHASES-1:0] i_elem_phase_alarm,
    input wire logic [N_ELEM*`PTA_PHASES-1:0] i_elem_phase_trip,
    input wire logic i_phase_phasor_ok,
    // Watched outputs
    input wire logic o_prot_active,
    input wire logic o_general_alarm,
    input wire logic o_general_trip,
    input wire logic [`PTA_PHASES-1:0] o_phase_collective_alarm,
    input wire logic [`PTA_PHASES-1:0] o_phase_collective_trip,
    input wire logic [N_ELEM-1:0] o_breaker_open_command,
    input wire logic [N_ELEM-1:0] o_elem_local_alarm,
    input wire logic [N_ELEM-1:0] o_elem_local_trip,
    input wire pta_pkg::pta_dir_e o_phase_direction,
    input wire pta_pkg::pta_dir_e o_ground_direction
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // Input seen one edge, output judged the next
    sequence s_meas_lost;
        !i_measured_values_ok ##1 1'b1;
    endsequence

    property p_gated;
        o_general_alarm || o_general_trip |-> o_prot_active;
    endproperty
    a_gated: assert property (p_gated)
        else $error("collective flag while frame inactive");
    property p_meas;
        s_meas_lost |-> !o_prot_active;
    endproperty
    a_meas: assert property (p_meas)
        else $error("frame active after invalid measurement");
    property p_busy;
        i_setting_change_busy |=> !o_prot_active;
    endproperty
    a_busy: assert property (p_busy)
        else $error("frame active during setting change");
    property p_gen_alarm;
        o_general_alarm |-> (|o_elem_local_alarm) && $past(|i_elem_alarm);
    endproperty
    a_gen_alarm: assert property (p_gen_alarm)
        else $error("general alarm without element alarm");
    property p_gen_trip;
        o_general_trip |-> (|o_elem_local_trip) && $past(|i_elem_trip);
    endproperty
    a_gen_trip: assert property (p_gen_trip)
        else $error("general trip without element trip");
    property p_cmd;
        (|o_breaker_open_command) |-> o_general_trip && o_prot_active;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("open command without general trip");
    property p_ph_alarm;
        (|o_phase_collective_alarm) |-> o_general_alarm && $past(|i_elem_phase_alarm);
    endproperty
    a_ph_alarm: assert property (p_ph_alarm)
        else $error("phase alarm without phase cause");
    property p_ph_trip;
        (|o_phase_collective_trip) |-> o_general_trip && $past(|i_elem_phase_trip);
    endproperty
    a_ph_trip: assert property (p_ph_trip)
        else $error("phase trip without phase cause");
    property p_dir_np;
        !i_phase_phasor_ok |=> o_phase_direction == pta_pkg::PTA_DIR_NOT_POSSIBLE;
    endproperty
    a_dir_np: assert property (p_dir_np)
        else $error("direction reported with small phasors");
    property p_gnd;
        o_ground_direction != pta_pkg::PTA_DIR_HIDDEN |-> |(o_elem_local_alarm | o_elem_local_trip);
    endproperty
    a_gnd: assert property (p_gnd)
        else $error("ground direction shown without fault");
endmodule : pta_checker

bind pta_protection_trip_aggregator pta_checker #(.N_ELEM(N_ELEM)) i_pta_checker (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_setting_change_busy(i_setting_change_busy), .i_measured_values_ok(i_measured_values_ok),
    .i_elem_alarm(i_elem_alarm), .i_elem_trip(i_elem_trip),
    .i_elem_phase_alarm(i_elem_phase_alarm), .i_elem_phase_trip(i_elem_phase_trip),
    .i_phase_phasor_ok(i_phase_phasor_ok), .o_prot_active(o_prot_active),
    .o_general_alarm(o_general_alarm), .o_general_trip(o_general_trip),
    .o_phase_collective_alarm(o_phase_collective_alarm),
    .o_phase_collective_trip(o_phase_collective_trip),
    .o_breaker_open_command(o_breaker_open_command),
    .o_elem_local_alarm(o_elem_local_alarm), .o_elem_local_trip(o_elem_local_trip),
    .o_phase_direction(o_phase_direction), .o_ground_direction(o_ground_direction));

//--- pta_consts.svh
// Purpose: Offsets, field positions, reset values and sizes for the protection
//          trip aggregator.
// Assumes: 32-bit register words at byte addresses, plain strobe port.
// Notes:   Definitions only.
`ifndef PTA_CONSTS_SVH
`define PTA_CONSTS_SVH

`define PTA_ADDR_W 8
`define PTA_DATA_W 32

`define PTA_OFS_CTRL 8'h00
`define PTA_OFS_SUPERV_ONLY 8'h04
`define PTA_OFS_SINGLE_PHASE 8'h08
`define PTA_OFS_DIR_ENABLE 8'h0c
`define PTA_OFS_DIR_REVERSE 8'h10
`define PTA_OFS_MTA 8'h14
`define PTA_OFS_STATUS 8'h18
`define PTA_OFS_IRQ_STATUS 8'h1c
`define PTA_OFS_IRQ_CLEAR 8'h20
`define PTA_OFS_IRQ_ENABLE 8'h24
`define PTA_OFS_CMD_BLOCK 8'h28

// Control register fields
`define PTA_CTRL_FUNCTION 0
`define PTA_CTRL_EXT_BLOCK_EN 1
`define PTA_CTRL_PERM_CMD_BLOCK 2
`define PTA_CTRL_EXT_CMD_BLOCK_EN 3
`define PTA_CTRL_ASSIGN_A 4
`define PTA_CTRL_ASSIGN_B 5
`define PTA_CTRL_ASSIGN_CMD 6
`define PTA_CTRL_W 7
`define PTA_CTRL_RESET 7'h00

// Status register fields
`define PTA_ST_ACTIVE 0
`define PTA_ST_GEN_ALARM 1
`define PTA_ST_GEN_TRIP 2
`define PTA_ST_PH_ALARM 3
`define PTA_ST_PH_TRIP 6
`define PTA_ST_PH_DIR 9
`define PTA_ST_GND_DIR 11
`define PTA_ST_BLOCKED 13
`define PTA_ST_CMD_BLOCKED 14

// Interrupt event bits
`define PTA_IRQ_ALARM 0
`define PTA_IRQ_TRIP 1
`define PTA_IRQ_CMD 2
`define PTA_IRQ_BLOCK 3
`define PTA_IRQ_W 4

`define PTA_MTA_PHASE_LSB 0
`define PTA_MTA_GND_LSB 8
`define PTA_ANGLE_W 8
`define PTA_PHASES 3
`define PTA_ELEMENTS 8

`endif

//--- pta_elem_model.sv
// Purpose: Behavioural protective elements feeding the aggregator.
// Assumes: Fault criterion given per element and phase by the bench.
// Notes:   Trip delay shortened; same for every element.
`timescale 1ns/1ps
module pta_elem_model #(
    parameter int N_ELEM = 8,
    parameter int TRIP_DELAY = 3
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Fault criterion, element e phase p at e*3+p
    input wire logic [N_ELEM*3-1:0] i_fault,
    // Element decisions
    output logic [N_ELEM-1:0] o_alarm,
    output logic [N_ELEM-1:0] o_trip,
    output logic [N_ELEM*3-1:0] o_phase_alarm,
    output logic [N_ELEM*3-1:0] o_phase_trip
);
    logic [7:0] cnt_q [N_ELEM];

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        for (int e = 0; e < N_ELEM; e++) begin
            // Fault gone restarts the delay, so a trip needs the criterion throughout
            if (!i_reset_n || i_fault[e*3 +: 3] == 3'h0) begin
                cnt_q[e] <= 8'h00;
            end else if (cnt_q[e] < TRIP_DELAY) begin
                cnt_q[e] <= cnt_q[e] + 8'h01;
            end
        end
    end

    always_comb begin
        for (int e = 0; e < N_ELEM; e++) begin
            o_alarm[e] = |i_fault[e*3 +: 3];
            o_trip[e] = o_alarm[e] && (cnt_q[e] >= TRIP_DELAY);
            o_phase_alarm[e*3 +: 3] = i_fault[e*3 +: 3];
            o_phase_trip[e*3 +: 3] = o_trip[e] ? i_fault[e*3 +: 3] : 3'h0;
        end
    end
endmodule : pta_elem_model

//--- pta_pkg.sv
// Purpose: Types shared by the protection trip aggregator.
// Assumes: Angles in binary units, a full turn is 256.
// Notes:   Direction result carried as a small enum.
package pta_pkg;

    typedef enum logic [1:0] {
        PTA_DIR_NOT_POSSIBLE,
        PTA_DIR_FORWARD,
        PTA_DIR_REVERSE,
        PTA_DIR_HIDDEN
    } pta_dir_e;

endpackage : pta_pkg

//--- pta_protection_trip_aggregator.sv
// Purpose: Master protection frame: gating, collective alarms and trips, trip commands.
// Assumes: Elements and assignment sources run on i_sys_clk; angle math done upstream.
// Notes:   Frame outputs are one register stage behind the element inputs; o_irq is two.
//
// Strobed register access and the register offsets are this design's own decisions.
`include "pta_consts.svh"
`timescale 1ns/1ps

module pta_protection_trip_aggregator #(
    parameter int N_ELEM = `PTA_ELEMENTS
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [`PTA_ADDR_W-1:0] i_addr,
    input wire logic [`PTA_DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [`PTA_DATA_W-1:0] o_rd_data,
    // Frame availability
    input wire logic i_setting_change_busy,
    input wire logic i_measured_values_ok,
    input wire logic i_external_block_input_a,
    input wire logic i_external_block_input_b,
    input wire logic i_external_trip_command_block_input,
    // Element decisions
    input wire logic [N_ELEM-1:0] i_elem_alarm,
    input wire logic [N_ELEM-1:0] i_elem_trip,
    input wire logic [N_ELEM*`PTA_PHASES-1:0] i_elem_phase_alarm,
    input wire logic [N_ELEM*`PTA_PHASES-1:0] i_elem_phase_trip,
    // Direction inputs
    input wire logic i_phase_phasor_ok,
    input wire logic [`PTA_ANGLE_W-1:0] i_phase_angle,
    input wire logic i_ground_phasor_ok,
    input wire logic [`PTA_ANGLE_W-1:0] i_ground_angle,
    // Frame outputs
    output logic o_prot_active,
    output logic o_general_alarm,
    output logic o_general_trip,
    output logic [`PTA_PHASES-1:0] o_phase_collective_alarm,
    output logic [`PTA_PHASES-1:0] o_phase_collective_trip,
    output logic [N_ELEM-1:0] o_breaker_open_command,
    output logic [N_ELEM-1:0] o_elem_local_alarm,
    output logic [N_ELEM-1:0] o_elem_local_trip,
    output pta_pkg::pta_dir_e o_phase_direction,
    output pta_pkg::pta_dir_e o_ground_direction,
    // Interrupt
    output logic o_irq
);

    localparam int PW = N_ELEM * `PTA_PHASES;

    // Settings
    logic [`PTA_CTRL_W-1:0] ctrl_q;
    logic [N_ELEM-1:0] superv_only_q;
    logic [N_ELEM-1:0] single_phase_q;
    logic [N_ELEM-1:0] dir_enable_q;
    logic [N_ELEM-1:0] dir_reverse_q;
    logic [N_ELEM-1:0] cmd_block_q;
    logic [`PTA_ANGLE_W-1:0] phase_mta_q;
    logic [`PTA_ANGLE_W-1:0] ground_mta_q;
    logic [`PTA_IRQ_W-1:0] irq_status_q;
    logic [`PTA_IRQ_W-1:0] irq_enable_q;

    logic function_on;
    logic ext_block_en;
    logic perm_cmd_block;
    logic ext_cmd_block_en;
    logic assign_a;
    logic assign_b;
    logic assign_cmd;

    assign function_on = ctrl_q[`PTA_CTRL_FUNCTION];
    assign ext_block_en = ctrl_q[`PTA_CTRL_EXT_BLOCK_EN];
    assign perm_cmd_block = ctrl_q[`PTA_CTRL_PERM_CMD_BLOCK];
    assign ext_cmd_block_en = ctrl_q[`PTA_CTRL_EXT_CMD_BLOCK_EN];
    assign assign_a = ctrl_q[`PTA_CTRL_ASSIGN_A];
    assign assign_b = ctrl_q[`PTA_CTRL_ASSIGN_B];
    assign assign_cmd = ctrl_q[`PTA_CTRL_ASSIGN_CMD];

    // Frame gating
    logic ext_block;
    logic frame_active;
    logic cmd_block;

    // Unassigned inputs are masked so a floating source cannot block
    assign ext_block = ext_block_en &
        ((assign_a & i_external_block_input_a) |
         (assign_b & i_external_block_input_b));
    assign frame_active = ~i_setting_change_busy & i_measured_values_ok &
        function_on & ~ext_block;
    assign cmd_block = perm_cmd_block |
        (ext_cmd_block_en & assign_cmd & i_external_trip_command_block_input);

    // Direction classification
    // Forward when operating angle lies strictly within 90 degrees of the direction angle
    function automatic pta_pkg::pta_dir_e classify(
        input logic ok,
        input logic [`PTA_ANGLE_W-1:0] angle,
        input logic [`PTA_ANGLE_W-1:0] mta
    );
        logic [`PTA_ANGLE_W-1:0] diff;
        diff = angle - mta;
        if (!ok) begin
            classify = pta_pkg::PTA_DIR_NOT_POSSIBLE;
        end else if ((diff[`PTA_ANGLE_W-1] == diff[`PTA_ANGLE_W-2]) &&
                     (diff != {2'b11, {(`PTA_ANGLE_W-2){1'b0}}})) begin
            classify = pta_pkg::PTA_DIR_FORWARD;
        end else begin
            // Exactly on the boundary line counts as reverse
            classify = pta_pkg::PTA_DIR_REVERSE;
        end
    endfunction : classify

    pta_pkg::pta_dir_e phase_dir;
    pta_pkg::pta_dir_e ground_dir;

    assign phase_dir = classify(i_phase_phasor_ok, i_phase_angle, phase_mta_q);
    assign ground_dir = classify(i_ground_phasor_ok, i_ground_angle, ground_mta_q);

    // Per-element forwarding
    logic [N_ELEM-1:0] fwd_alarm;
    logic [N_ELEM-1:0] fwd_trip;
    logic [N_ELEM-1:0] loc_alarm;
    logic [N_ELEM-1:0] loc_trip;
    logic [N_ELEM-1:0] cmd_d;
    logic [PW-1:0] fwd_ph_alarm;
    logic [PW-1:0] fwd_ph_trip;
    logic [N_ELEM-1:0] dir_ok;

    genvar g;
    generate
        for (g = 0; g < N_ELEM; g++) begin : g_elem
            // Element trip arrives already delayed by its own timer
            assign dir_ok[g] = ~dir_enable_q[g] |
                (dir_reverse_q[g] ? (phase_dir == pta_pkg::PTA_DIR_REVERSE)
                                  : (phase_dir == pta_pkg::PTA_DIR_FORWARD));
            assign loc_alarm[g] = frame_active & i_elem_alarm[g];
            assign loc_trip[g] = frame_active & i_elem_trip[g] & dir_ok[g];
            assign fwd_alarm[g] = loc_alarm[g] & ~superv_only_q[g];
            assign fwd_trip[g] = loc_trip[g] & ~superv_only_q[g];
            assign fwd_ph_alarm[g*`PTA_PHASES +: `PTA_PHASES] =
                i_elem_phase_alarm[g*`PTA_PHASES +: `PTA_PHASES] &
                {`PTA_PHASES{fwd_alarm[g] & single_phase_q[g]}};
            assign fwd_ph_trip[g*`PTA_PHASES +: `PTA_PHASES] =
                i_elem_phase_trip[g*`PTA_PHASES +: `PTA_PHASES] &
                {`PTA_PHASES{fwd_trip[g] & single_phase_q[g]}};
            // Supervision-only elements never reach the trip manager
            assign cmd_d[g] = fwd_trip[g] & ~cmd_block & ~cmd_block_q[g];
        end
    endgenerate

    logic gen_alarm_d;
    logic gen_trip_d;
    logic [`PTA_PHASES-1:0] ph_alarm_d;
    logic [`PTA_PHASES-1:0] ph_trip_d;

    assign gen_alarm_d = |fwd_alarm;
    assign gen_trip_d = |fwd_trip;

    always_comb begin
        ph_alarm_d = '0;
        ph_trip_d = '0;
        for (int e = 0; e < N_ELEM; e++) begin
            ph_alarm_d = ph_alarm_d | fwd_ph_alarm[e*`PTA_PHASES +: `PTA_PHASES];
            ph_trip_d = ph_trip_d | fwd_ph_trip[e*`PTA_PHASES +: `PTA_PHASES];
        end
    end

    // Registered frame outputs
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prot_active <= 1'b0;
            o_general_alarm <= 1'b0;
            o_general_trip <= 1'b0;
            o_phase_collective_alarm <= '0;
            o_phase_collective_trip <= '0;
            o_breaker_open_command <= '0;
            o_elem_local_alarm <= '0;
            o_elem_local_trip <= '0;
        end else begin
            o_prot_active <= frame_active;
            o_general_alarm <= gen_alarm_d;
            o_general_trip <= gen_trip_d;
            o_phase_collective_alarm <= ph_alarm_d;
            o_phase_collective_trip <= ph_trip_d;
            o_breaker_open_command <= cmd_d;
            o_elem_local_alarm <= loc_alarm;
            o_elem_local_trip <= loc_trip;
        end
    end

    // Direction outputs
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_phase_direction <= pta_pkg::PTA_DIR_NOT_POSSIBLE;
            o_ground_direction <= pta_pkg::PTA_DIR_HIDDEN;
        end else begin
            o_phase_direction <= phase_dir;
            // Ground result only meaningful during a fault event
            if (gen_alarm_d || gen_trip_d) begin
                o_ground_direction <= ground_dir;
            end else begin
                o_ground_direction <= pta_pkg::PTA_DIR_HIDDEN;
            end
        end
    end

    // Settings registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= `PTA_CTRL_RESET;
            superv_only_q <= '0;
            single_phase_q <= '0;
            dir_enable_q <= '0;
            dir_reverse_q <= '0;
            cmd_block_q <= '0;
            phase_mta_q <= '0;
            ground_mta_q <= '0;
            irq_enable_q <= '0;
        end else if (i_wr_en) begin
            case (i_addr)
                `PTA_OFS_CTRL: begin
                    ctrl_q <= i_wr_data[`PTA_CTRL_W-1:0];
                end
                `PTA_OFS_SUPERV_ONLY: begin
                    superv_only_q <= i_wr_data[N_ELEM-1:0];
                end
                `PTA_OFS_SINGLE_PHASE: begin
                    single_phase_q <= i_wr_data[N_ELEM-1:0];
                end
                `PTA_OFS_DIR_ENABLE: begin
                    dir_enable_q <= i_wr_data[N_ELEM-1:0];
                end
                `PTA_OFS_DIR_REVERSE: begin
                    dir_reverse_q <= i_wr_data[N_ELEM-1:0];
                end
                `PTA_OFS_CMD_BLOCK: begin
                    cmd_block_q <= i_wr_data[N_ELEM-1:0];
                end
                `PTA_OFS_MTA: begin
                    phase_mta_q <= i_wr_data[`PTA_MTA_PHASE_LSB +: `PTA_ANGLE_W];
                    ground_mta_q <= i_wr_data[`PTA_MTA_GND_LSB +: `PTA_ANGLE_W];
                end
                `PTA_OFS_IRQ_ENABLE: begin
                    irq_enable_q <= i_wr_data[`PTA_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Interrupt events: rising edges of collective conditions
    logic [`PTA_IRQ_W-1:0] event_now;
    logic [`PTA_IRQ_W-1:0] event_prev_q;
    logic [`PTA_IRQ_W-1:0] event_pulse;
    logic [`PTA_IRQ_W-1:0] irq_clear;

    assign event_now = {~frame_active, |cmd_d, gen_trip_d, gen_alarm_d};
    assign event_pulse = event_now & ~event_prev_q;
    assign irq_clear = (i_wr_en && (i_addr == `PTA_OFS_IRQ_CLEAR)) ?
        i_wr_data[`PTA_IRQ_W-1:0] : '0;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            event_prev_q <= '0;
        end else begin
            event_prev_q <= event_now;
        end
    end

    // A new event in the clear cycle survives the clear
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | event_pulse;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_q & irq_enable_q);
        end
    end

    // Read port: data one cycle after the strobe, zero otherwise
    logic [`PTA_DATA_W-1:0] status_word;
    logic [`PTA_DATA_W-1:0] rd_mux;

    always_comb begin
        status_word = '0;
        status_word[`PTA_ST_ACTIVE] = o_prot_active;
        status_word[`PTA_ST_GEN_ALARM] = o_general_alarm;
        status_word[`PTA_ST_GEN_TRIP] = o_general_trip;
        status_word[`PTA_ST_PH_ALARM +: `PTA_PHASES] = o_phase_collective_alarm;
        status_word[`PTA_ST_PH_TRIP +: `PTA_PHASES] = o_phase_collective_trip;
        status_word[`PTA_ST_PH_DIR +: 2] = o_phase_direction;
        status_word[`PTA_ST_GND_DIR +: 2] = o_ground_direction;
        status_word[`PTA_ST_BLOCKED] = ext_block;
        status_word[`PTA_ST_CMD_BLOCKED] = cmd_block;
    end

    always_comb begin
        rd_mux = '0;
        case (i_addr)
            `PTA_OFS_CTRL: rd_mux[`PTA_CTRL_W-1:0] = ctrl_q;
            `PTA_OFS_SUPERV_ONLY: rd_mux[N_ELEM-1:0] = superv_only_q;
            `PTA_OFS_SINGLE_PHASE: rd_mux[N_ELEM-1:0] = single_phase_q;
            `PTA_OFS_DIR_ENABLE: rd_mux[N_ELEM-1:0] = dir_enable_q;
            `PTA_OFS_DIR_REVERSE: rd_mux[N_ELEM-1:0] = dir_reverse_q;
            `PTA_OFS_CMD_BLOCK: rd_mux[N_ELEM-1:0] = cmd_block_q;
            `PTA_OFS_MTA: begin
                rd_mux[`PTA_MTA_PHASE_LSB +: `PTA_ANGLE_W] = phase_mta_q;
                rd_mux[`PTA_MTA_GND_LSB +: `PTA_ANGLE_W] = ground_mta_q;
            end
            `PTA_OFS_STATUS: rd_mux = status_word;
            `PTA_OFS_IRQ_STATUS: rd_mux[`PTA_IRQ_W-1:0] = irq_status_q;
            `PTA_OFS_IRQ_ENABLE: rd_mux[`PTA_IRQ_W-1:0] = irq_enable_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= '0;
        end
    end

endmodule : pta_protection_trip_aggregator

//--- pta_protection_trip_aggregator_tb_top.sv
// Purpose: Self-checking bench for the protection trip aggregator.
// Assumes: Element 2 phase 1 carries every test fault.
// Notes:   Model trip delay is 3 cycles.
`include "pta_consts.svh"
`timescale 1ns/1ps
module pta_protection_trip_aggregator_tb_top;
    localparam logic [23:0] F = 24'h000080;
    logic clk, rst_n, we, re, busy, mok, ba, bb, cb, pok, gok, act, gal, gtr, irq;
    logic [7:0] addr, pang, gang, cmd, lal, ltr, alm, trp;
    logic [31:0] wdat, rdat;
    logic [23:0] flt, palm, ptrp;
    logic [2:0] cal, ctr;
    pta_pkg::pta_dir_e pdir, gdir;
    int error_cnt = 0;
    int compares = 0;

    pta_elem_model i_elems (.i_sys_clk(clk), .i_reset_n(rst_n), .i_fault(flt),
        .o_alarm(alm), .o_trip(trp), .o_phase_alarm(palm), .o_phase_trip(ptrp));
    pta_protection_trip_aggregator i_dut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_addr(addr), .i_wr_data(wdat), .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdat),
        .i_setting_change_busy(busy), .i_measured_values_ok(mok),
        .i_external_block_input_a(ba), .i_external_block_input_b(bb),
        .i_external_trip_command_block_input(cb), .i_elem_alarm(alm), .i_elem_trip(trp),
        .i_elem_phase_alarm(palm), .i_elem_phase_trip(ptrp), .i_phase_phasor_ok(pok),
        .i_phase_angle(pang), .i_ground_phasor_ok(gok), .i_ground_angle(gang),
        .o_prot_active(act), .o_general_alarm(gal), .o_general_trip(gtr),
        .o_phase_collective_alarm(cal), .o_phase_collective_trip(ctr),
        .o_breaker_open_command(cmd), .o_elem_local_alarm(lal), .o_elem_local_trip(ltr),
        .o_phase_direction(pdir), .o_ground_direction(gdir), .o_irq(irq));

    always #2 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk(name, exp, rdat);
    endtask : rdchk
    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic t_reset();
        chk("active", 0, act);
        chk("gnd_dir", 3, gdir);
        rdchk("ctrl", `PTA_OFS_CTRL, 0);
        rdchk("unmapped", 8'h3c, 0);
        rdchk("irq_status", `PTA_OFS_IRQ_STATUS, 32'h8);
    endtask : t_reset
    task automatic t_avail();
        wr(`PTA_OFS_CTRL, 32'h01);
        tick(2);
        chk("active", 1, act);
        busy <= @(posedge clk) 1'b1;
        tick(2);
        chk("active_busy", 0, act);
        {busy, mok} <= @(posedge clk) 2'h0;
        tick(2);
        chk("active_meas", 0, act);
        {mok, flt} <= @(posedge clk) {1'b1, F};
        wr(`PTA_OFS_CTRL, 32'h00);
        tick(2);
        chk("alarm_off", 0, gal);
        chk("local_off", 0, lal);
        flt <= @(posedge clk) 24'h0;
    endtask : t_avail
    task automatic t_ext_block();
        wr(`PTA_OFS_CTRL, 32'h13);
        bb <= 1'b1;
        tick(2);
        chk("active_unassigned", 1, act);
        {ba, flt} <= @(posedge clk) {1'b1, F};
        tick(2);
        chk("active_blocked", 0, act);
        chk("alarm_blocked", 0, gal);
        ba <= @(posedge clk) 1'b0;
        tick(2);
        chk("alarm_released", 1, gal);
        wr(`PTA_OFS_CTRL, 32'h23);
        tick(2);
        chk("active_b_blocked", 0, act);
        {bb, flt} <= @(posedge clk) 25'h0;
    endtask : t_ext_block
    task automatic t_trip();
        wr(`PTA_OFS_SINGLE_PHASE, 32'h04);
        wr(`PTA_OFS_CTRL, 32'h01);
        flt <= F;
        tick(2);
        chk("gen_alarm", 1, gal);
        chk("ph_alarm", 3'h2, cal);
        chk("gen_trip_early", 0, gtr);
        tick(4);
        chk("gen_trip", 1, gtr);
        chk("ph_trip", 3'h2, ctr);
        chk("cmd", 8'h04, cmd);
        rdchk("status", `PTA_OFS_STATUS, 32'h97);
        flt <= @(posedge clk) 24'h0;
        tick(2);
        chk("alarm_gone", 0, gal);
    endtask : t_trip
    task automatic t_cmd_block();
        flt <= @(posedge clk) F;
        wr(`PTA_OFS_CTRL, 32'h05);
        tick(6);
        chk("perm_trip", 1, gtr);
        chk("perm_alarm", 1, gal);
        chk("perm_cmd", 0, cmd);
        wr(`PTA_OFS_CTRL, 32'h49);
        cb <= 1'b1;
        tick(2);
        chk("ext_cmd", 0, cmd);
        cb <= @(posedge clk) 1'b0;
        tick(2);
        chk("ext_cmd_rel", 8'h04, cmd);
        wr(`PTA_OFS_CMD_BLOCK, 32'h04);
        tick(2);
        chk("elem_cmd_blk", 0, cmd);
        wr(`PTA_OFS_CMD_BLOCK, 32'h00);
        flt <= 24'h0;
    endtask : t_cmd_block
    task automatic t_superv();
        wr(`PTA_OFS_SUPERV_ONLY, 32'h04);
        wr(`PTA_OFS_CTRL, 32'h01);
        flt <= F;
        tick(6);
        chk("loc_alarm", 8'h04, lal);
        chk("loc_trip", 8'h04, ltr);
        chk("sv_alarm", 0, gal);
        chk("sv_trip", 0, gtr);
        chk("sv_cmd", 0, cmd);
        flt <= @(posedge clk) 24'h0;
        wr(`PTA_OFS_SUPERV_ONLY, 32'h00);
    endtask : t_superv
    task automatic t_direction();
        wr(`PTA_OFS_DIR_ENABLE, 32'h04);
        wr(`PTA_OFS_MTA, 32'h00);
        pok <= 1'b1;
        gok <= 1'b1;
        pang <= 8'h10;
        gang <= 8'hc0;
        tick(2);
        chk("ph_dir", 1, pdir);
        chk("gnd_hidden", 3, gdir);
        flt <= @(posedge clk) F;
        tick(6);
        chk("fwd_cmd", 8'h04, cmd);
        chk("gnd_dir", 2, gdir);
        pang <= @(posedge clk) 8'h40;
        tick(2);
        chk("ph_rev", 2, pdir);
        chk("rev_cmd", 0, cmd);
        pok <= @(posedge clk) 1'b0;
        tick(2);
        chk("ph_np", 0, pdir);
        wr(`PTA_OFS_DIR_REVERSE, 32'h04);
        pok <= 1'b1;
        tick(2);
        chk("rev_set_cmd", 8'h04, cmd);
        flt <= @(posedge clk) 24'h0;
        wr(`PTA_OFS_DIR_ENABLE, 32'h00);
    endtask : t_direction
    task automatic t_irq();
        wr(`PTA_OFS_IRQ_CLEAR, 32'h0f);
        wr(`PTA_OFS_IRQ_ENABLE, 32'h01);
        tick(2);
        chk("irq_idle", 0, irq);
        flt <= @(posedge clk) F;
        tick(3);
        chk("irq_set", 1, irq);
        flt <= @(posedge clk) 24'h0;
        tick(2);
        chk("irq_sticky", 1, irq);
        wr(`PTA_OFS_IRQ_CLEAR, 32'h01);
        tick(2);
        chk("irq_clear", 0, irq);
    endtask : t_irq

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {we, re, busy, ba, bb, cb, pok, gok} = 8'h00;
        mok = 1'b1;
        {addr, pang, gang} = 24'h0;
        wdat = 32'h0;
        flt = 24'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_avail();
        t_ext_block();
        t_trip();
        t_cmd_block();
        t_superv();
        t_direction();
        t_irq();
        summarize();
    end

    // Scenarios need about 125 cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("unexpected watchdog: expected done, seen hang");
        summarize();
    end
endmodule : pta_protection_trip_aggregator_tb_top
